// [rtl/alsc_pkg.sv]
// constants and types for the converter list and status control block
`default_nettype none
package alsc_pkg;
  // ------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [5:0] CONTROL_IDX = 6'h00;
  localparam logic [5:0] CONVERTER_STATUS_IDX = 6'h02;
  localparam logic [5:0] IRQ_STATUS_IDX = 6'h03;
  localparam logic [5:0] IRQ_MASK_IDX = 6'h04;
  localparam logic [5:0] FLAG_SELECT_IDX = 6'h05;

  // ------------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------------
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_SPECIAL_ACCESS_BIT = 1;
  localparam int CTL_CMD_BMOD_BIT = 2;
  localparam int CTL_RES_BMOD_BIT = 3;
  localparam int CTL_LOAD_OK_BIT = 4;
  localparam int CTL_RESTART_BIT = 5;
  localparam int CTL_SOFT_RESET_BIT = 6;

  // ------------------------------------------------------------------
  // converter status fields
  // ------------------------------------------------------------------
  localparam int STS_CMD_SEL_BIT = 7;
  localparam int STS_RES_SEL_BIT = 6;
  localparam int STS_DBL_ERR_BIT = 5;
  localparam int STS_READY_BIT = 3;

  // ------------------------------------------------------------------
  // interrupt status and mask fields, flag select field
  // ------------------------------------------------------------------
  localparam int IRQ_DBL_ERR_BIT = 0;
  localparam int IRQ_SEQ_DONE_BIT = 1;
  localparam int IRQ_ABORT_DONE_BIT = 2;
  localparam int IRQ_WIDTH = 3;
  localparam int SEL_WIDTH = 4;
  localparam int FLAG_LSB = 16;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 3'h0;
  localparam logic [SEL_WIDTH-1:0] SEL_RESET = 4'h0;

  // sequencer states
  typedef enum logic [1:0] {
    ALSC_IDLE,
    ALSC_RUN,
    ALSC_ABORT,
    ALSC_HALT
  } alsc_seq_type;
endpackage : alsc_pkg
`default_nettype wire

// [rtl/alsc_top.sv]
// converter list selection, status flags and interrupt logic
`default_nettype none
module alsc_top #(
  parameter int ADDR_WIDTH = 8,
  parameter int FLAG_COUNT = 15
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sequence_done,
  input wire logic sequence_abort,
  input wire logic abort_done,
  input wire logic first_result_stored,
  input wire logic ecc_error_load,
  input wire logic ecc_error_store,
  output logic command_list_select,
  output logic result_list_select,
  output logic double_bit_error_flag,
  output logic ready,
  output logic sequence_active,
  output logic sequence_start,
  output logic [FLAG_COUNT-1:0] conversion_interrupt_flags,
  output logic irq
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  // the word index is cut from address bits 7 down to 2
  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 16) begin : g_bad_addr
    $error("address width must lie between 8 and 16");
  end
  if (FLAG_COUNT != (1 << alsc_pkg::SEL_WIDTH) - 1) begin : g_bad_flags
    $error("flag count must match the four-bit selector");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    alsc_pkg::alsc_seq_type seq;
    logic enable;
    logic special_mode_access;
    logic command_list_buffer_mode;
    logic result_list_buffer_mode;
    logic load_ok;
    logic restart_request;
    logic command_list_select;
    logic result_list_select;
    logic double_bit_error_flag;
    logic result_list_primed;
    logic ready;
    logic start;
    logic active;
    logic [alsc_pkg::SEL_WIDTH-1:0] interrupt_flag_selector;
    logic [FLAG_COUNT-1:0] flags;
    logic [alsc_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [alsc_pkg::IRQ_WIDTH-1:0] irq_mask;
    logic irq;
    logic waitrequest;
    logic [31:0] readdata;
  } alsc_state_type;

  alsc_state_type cur;
  alsc_state_type next_cur;

  // byte address bits 1:0 are ignored; every register is a whole word
  logic [5:0] word_index;
  assign word_index = avs_address[7:2];

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic wr_go;
    logic soft_reset;
    logic sel_writable;
    logic ecc_event;
    logic cmd_toggle;
    logic res_event;
    logic [alsc_pkg::IRQ_WIDTH-1:0] irq_set;
    logic [alsc_pkg::IRQ_WIDTH-1:0] irq_clr;
    logic [31:0] rd;
    wr_go = 1'b0;
    soft_reset = 1'b0;
    sel_writable = 1'b0;
    ecc_event = 1'b0;
    cmd_toggle = 1'b0;
    res_event = 1'b0;
    irq_set = alsc_pkg::IRQ_RESET;
    irq_clr = alsc_pkg::IRQ_RESET;
    rd = alsc_pkg::DATA_ZERO;
    next_cur = cur;
    next_cur.start = 1'b0;

    // bus handshake: one wait cycle, then the access completes
    // waitrequest drops for one cycle only; a fresh request waits a cycle
    next_cur.waitrequest = !((avs_read || avs_write) && cur.waitrequest);
    wr_go = avs_write && !cur.waitrequest;
    sel_writable = !cur.enable || cur.special_mode_access;

    // register writes
    if (wr_go) begin
      unique case (word_index)
        alsc_pkg::CONTROL_IDX: begin
          next_cur.enable = avs_writedata[alsc_pkg::CTL_ENABLE_BIT];
          next_cur.special_mode_access =
            avs_writedata[alsc_pkg::CTL_SPECIAL_ACCESS_BIT];
          next_cur.command_list_buffer_mode =
            avs_writedata[alsc_pkg::CTL_CMD_BMOD_BIT];
          next_cur.result_list_buffer_mode =
            avs_writedata[alsc_pkg::CTL_RES_BMOD_BIT];
          // load-ok and restart are set by software, consumed by hardware
          if (avs_writedata[alsc_pkg::CTL_LOAD_OK_BIT]) begin
            next_cur.load_ok = 1'b1;
          end
          if (avs_writedata[alsc_pkg::CTL_RESTART_BIT]) begin
            next_cur.restart_request = 1'b1;
          end
          soft_reset = avs_writedata[alsc_pkg::CTL_SOFT_RESET_BIT];
        end
        alsc_pkg::CONVERTER_STATUS_IDX: begin
          // error and ready bits ignore writes
          if (sel_writable) begin
            next_cur.command_list_select =
              avs_writedata[alsc_pkg::STS_CMD_SEL_BIT];
            next_cur.result_list_select =
              avs_writedata[alsc_pkg::STS_RES_SEL_BIT];
          end
        end
        alsc_pkg::IRQ_STATUS_IDX: begin
          irq_clr = avs_writedata[alsc_pkg::IRQ_WIDTH-1:0];
        end
        alsc_pkg::IRQ_MASK_IDX: begin
          next_cur.irq_mask = avs_writedata[alsc_pkg::IRQ_WIDTH-1:0];
        end
        alsc_pkg::FLAG_SELECT_IDX: begin
          next_cur.interrupt_flag_selector =
            avs_writedata[alsc_pkg::SEL_WIDTH-1:0];
        end
        default: begin
          // unmapped word: write is dropped
        end
      endcase
    end

    // ecc errors only count while the converter is enabled
    ecc_event = cur.enable && (ecc_error_load || ecc_error_store);

    // sequencer
    unique case (cur.seq)
      alsc_pkg::ALSC_IDLE: begin
        if (cur.enable && cur.restart_request) begin
          // a restart needs load-ok to swap lists in double mode
          cmd_toggle = cur.load_ok && !cur.command_list_buffer_mode;
          next_cur.restart_request = 1'b0;
          if (cur.load_ok) begin
            next_cur.load_ok = 1'b0;
          end
          next_cur.seq = alsc_pkg::ALSC_RUN;
          next_cur.start = 1'b1;
        end
      end
      alsc_pkg::ALSC_RUN: begin
        if (sequence_abort) begin
          next_cur.seq = alsc_pkg::ALSC_ABORT;
        end else if (sequence_done) begin
          next_cur.seq = alsc_pkg::ALSC_IDLE;
          irq_set[alsc_pkg::IRQ_SEQ_DONE_BIT] = 1'b1;
        end
      end
      alsc_pkg::ALSC_ABORT: begin
        // ready stays low until the abort has fully drained
        if (abort_done) begin
          next_cur.seq = alsc_pkg::ALSC_IDLE;
          irq_set[alsc_pkg::IRQ_ABORT_DONE_BIT] = 1'b1;
        end
      end
      alsc_pkg::ALSC_HALT: begin
        // only a soft reset or disable leaves this state
        next_cur.seq = alsc_pkg::ALSC_HALT;
      end
    endcase

    // command list select toggle
    if (cmd_toggle) begin
      next_cur.command_list_select = !cur.command_list_select;
    end

    // result list select toggles once the initial list is stored
    res_event = cur.enable && cur.seq != alsc_pkg::ALSC_HALT &&
                (first_result_stored || sequence_abort);
    if (res_event && !cur.result_list_buffer_mode) begin
      next_cur.result_list_primed = 1'b1;
      if (cur.result_list_primed) begin
        next_cur.result_list_select = !cur.result_list_select;
      end
    end

    // soft reset brings lists and sequencer back to a clean idle
    if (soft_reset) begin
      next_cur.command_list_select = 1'b0;
      next_cur.result_list_select = 1'b0;
      next_cur.double_bit_error_flag = 1'b0;
      next_cur.result_list_primed = 1'b0;
      next_cur.load_ok = 1'b0;
      next_cur.restart_request = 1'b0;
      next_cur.seq = alsc_pkg::ALSC_IDLE;
      next_cur.start = 1'b0;
    end

    // an ecc error in the same cycle as a soft reset still halts
    if (ecc_event) begin
      next_cur.double_bit_error_flag = 1'b1;
      next_cur.seq = alsc_pkg::ALSC_HALT;
      next_cur.start = 1'b0;
      irq_set[alsc_pkg::IRQ_DBL_ERR_BIT] = 1'b1;
    end

    // disabling the converter drops the error and the sequence
    if (!next_cur.enable) begin
      next_cur.double_bit_error_flag = 1'b0;
      next_cur.seq = alsc_pkg::ALSC_IDLE;
      next_cur.start = 1'b0;
      next_cur.result_list_primed = 1'b0;
    end

    // single buffer modes pin the selects low
    if (next_cur.command_list_buffer_mode) begin
      next_cur.command_list_select = 1'b0;
    end
    if (next_cur.result_list_buffer_mode) begin
      next_cur.result_list_select = 1'b0;
    end

    // ready reflects the state being entered
    next_cur.ready = next_cur.seq == alsc_pkg::ALSC_IDLE &&
                     !next_cur.double_bit_error_flag;

    // busy pin from a flop of its own, so a state decode never glitches it
    next_cur.active = next_cur.seq == alsc_pkg::ALSC_RUN ||
                      next_cur.seq == alsc_pkg::ALSC_ABORT;

    // one-hot conversion flags; selector value k lights flag k-1, zero lights none
    next_cur.flags = '0;
    if (next_cur.interrupt_flag_selector != alsc_pkg::SEL_RESET) begin
      next_cur.flags[next_cur.interrupt_flag_selector - 4'h1] = 1'b1;
    end

    // sticky interrupt bits, set wins over a write-one clear
    next_cur.irq_status = (cur.irq_status & ~irq_clr) | irq_set;
    next_cur.irq = |(next_cur.irq_status & next_cur.irq_mask);

    // read data captured in the wait cycle
    // a read held high past its answer is simply taken as a new access
    unique case (word_index)
      alsc_pkg::CONTROL_IDX: begin
        rd[alsc_pkg::CTL_ENABLE_BIT] = cur.enable;
        rd[alsc_pkg::CTL_SPECIAL_ACCESS_BIT] = cur.special_mode_access;
        rd[alsc_pkg::CTL_CMD_BMOD_BIT] = cur.command_list_buffer_mode;
        rd[alsc_pkg::CTL_RES_BMOD_BIT] = cur.result_list_buffer_mode;
        rd[alsc_pkg::CTL_LOAD_OK_BIT] = cur.load_ok;
        rd[alsc_pkg::CTL_RESTART_BIT] = cur.restart_request;
      end
      alsc_pkg::CONVERTER_STATUS_IDX: begin
        rd[alsc_pkg::STS_CMD_SEL_BIT] = cur.command_list_select;
        rd[alsc_pkg::STS_RES_SEL_BIT] = cur.result_list_select;
        rd[alsc_pkg::STS_DBL_ERR_BIT] = cur.double_bit_error_flag;
        rd[alsc_pkg::STS_READY_BIT] = cur.ready;
      end
      alsc_pkg::IRQ_STATUS_IDX: begin
        rd[alsc_pkg::IRQ_WIDTH-1:0] = cur.irq_status;
      end
      alsc_pkg::IRQ_MASK_IDX: begin
        rd[alsc_pkg::IRQ_WIDTH-1:0] = cur.irq_mask;
      end
      alsc_pkg::FLAG_SELECT_IDX: begin
        rd[alsc_pkg::SEL_WIDTH-1:0] = cur.interrupt_flag_selector;
        rd[alsc_pkg::FLAG_LSB +: FLAG_COUNT] = cur.flags;
      end
      default: begin
        rd = alsc_pkg::DATA_ZERO;
      end
    endcase
    if (avs_read && cur.waitrequest) begin
      next_cur.readdata = rd;
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
      cur.seq <= alsc_pkg::ALSC_IDLE;
      cur.ready <= 1'b1;
      cur.waitrequest <= 1'b1;
      cur.interrupt_flag_selector <= alsc_pkg::SEL_RESET;
      cur.irq_status <= alsc_pkg::IRQ_RESET;
      cur.irq_mask <= alsc_pkg::IRQ_RESET;
      cur.readdata <= alsc_pkg::DATA_ZERO;
    end else begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from the state register
  // ------------------------------------------------------------------
  assign avs_readdata = cur.readdata;
  assign avs_waitrequest = cur.waitrequest;
  assign command_list_select = cur.command_list_select;
  assign result_list_select = cur.result_list_select;
  assign double_bit_error_flag = cur.double_bit_error_flag;
  assign ready = cur.ready;
  assign sequence_active = cur.active;
  assign sequence_start = cur.start;
  assign conversion_interrupt_flags = cur.flags;
  assign irq = cur.irq;

endmodule : alsc_top
`default_nettype wire

// [verification/alsc_monitor.sv]
// assertion checker for the list and status control block
`default_nettype none
module alsc_monitor #(
  parameter int ADDR_WIDTH = 8,
  parameter int FLAG_COUNT = 15
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic ecc_error_load,
  input wire logic ecc_error_store,
  input wire logic command_list_select,
  input wire logic result_list_select,
  input wire logic double_bit_error_flag,
  input wire logic ready,
  input wire logic sequence_active,
  input wire logic sequence_start,
  input wire logic [FLAG_COUNT-1:0] conversion_interrupt_flags
);
  // ------------------------------------------------------------------
  // control shadow
  // ------------------------------------------------------------------
  logic [3:0] ctl_q;
  logic wr_done;
  logic [5:0] idx;
  logic ctl_wr;
  assign idx = avs_address[7:2];
  assign wr_done = avs_write && !avs_waitrequest;
  assign ctl_wr = wr_done && idx == alsc_pkg::CONTROL_IDX;
  // only the level bits are kept; self-clearing bits are not tracked
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_q <= 4'h0;
    end else if (ctl_wr) begin
      ctl_q <= avs_writedata[3:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  err_halts_a: assert property (double_bit_error_flag |-> !ready &&
    !sequence_active && !sequence_start) else $error("run while halted");
  err_sticky_a: assert property (double_bit_error_flag && !wr_done
    |=> double_bit_error_flag) else $error("error flag lost");
  soft_sel_a: assert property (ctl_wr && avs_writedata[6] |-> ##2
    !command_list_select && !result_list_select) else $error("sel kept");
  // an ecc error in the very cycle of the soft reset still wins
  soft_idle_a: assert property (ctl_wr && avs_writedata[6] &&
    !ecc_error_load && !ecc_error_store |=> ready)
    else $error("not idle after soft reset");
  sel_locked_a: assert property (wr_done && ctl_q[0] && !ctl_q[1] &&
    idx == alsc_pkg::CONVERTER_STATUS_IDX |=> $stable(command_list_select)
    && $stable(result_list_select)) else $error("locked select written");
  start_pulse_a: assert property (sequence_start |-> sequence_active &&
    !ready ##1 !sequence_start) else $error("bad start pulse");
  cmd_toggle_a: assert property ($changed(command_list_select) |->
    sequence_start || $past(avs_write) || $past(avs_write, 2))
    else $error("command select moved alone");
  cmd_single_a: assert property (ctl_q[2] |=> !command_list_select)
    else $error("command select in single mode");
  res_single_a: assert property (ctl_q[3] |=> !result_list_select)
    else $error("result select in single mode");
  // a disable landing in the same cycle clears the flag instead
  err_set_a: assert property ((ecc_error_load || ecc_error_store) &&
    ctl_q[0] && !(ctl_wr && !avs_writedata[0]) |=> double_bit_error_flag)
    else $error("error not flagged");
  err_off_a: assert property (!ctl_q[0] |=> !double_bit_error_flag)
    else $error("error flag while disabled");
  ready_idle_a: assert property (ready |-> !sequence_active &&
    !double_bit_error_flag) else $error("ready while busy");
  flag_hot_a: assert property ($onehot0(conversion_interrupt_flags))
    else $error("flags not one-hot");
  // main scenarios reached
  cover property (sequence_start && command_list_select);
  cover property ($rose(double_bit_error_flag));
  cover property ($fell(result_list_select) && sequence_active);
endmodule : alsc_monitor
bind alsc_top alsc_monitor #(.ADDR_WIDTH(ADDR_WIDTH),
  .FLAG_COUNT(FLAG_COUNT)) mon (.sys_clk, .nrst, .avs_address, .avs_write,
  .avs_writedata, .avs_waitrequest, .ecc_error_load, .ecc_error_store,
  .command_list_select, .result_list_select, .double_bit_error_flag,
  .ready, .sequence_active, .sequence_start, .conversion_interrupt_flags);
`default_nettype wire

// [verification/alsc_top_bench.sv]
// self-checking bench for the list and status control block
`default_nettype none
module alsc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // done, abort, abort done, first result, ecc load, ecc store
  logic [5:0] ev = 6'h00;
  logic cmd, res, err, rdy, act, start, irq;
  logic [14:0] flags;
  logic [31:0] rv;
  logic [31:0] e;
  int bad_count = 0;
  int comparisons = 0;
  always #2.5 sys_clk = ~sys_clk;
  alsc_top DUT (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sequence_done(ev[0]),
    .sequence_abort(ev[1]), .abort_done(ev[2]),
    .first_result_stored(ev[3]), .ecc_error_load(ev[4]),
    .ecc_error_store(ev[5]), .command_list_select(cmd),
    .result_list_select(res), .double_bit_error_flag(err), .ready(rdy),
    .sequence_active(act), .sequence_start(start),
    .conversion_interrupt_flags(flags), .irq(irq));
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // waitrequest and read data are the values sampled at the rising edge;
  // one idle edge follows so the next call never re-raises in one step
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 40) bad_count++;
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0000_0000);
    chk(rv, x);
  endtask : rd
  task automatic pulse(input logic [5:0] v);
    ev <= v;
    @(posedge sys_clk);
    ev <= 6'h00;
    @(posedge sys_clk);
  endtask : pulse
  // order: command sel, result sel, error, ready, active, irq
  task automatic outs(input logic [5:0] x);
    repeat (2) @(negedge sys_clk);
    chk({26'h000_0000, cmd, res, err, rdy, act, irq}, {26'h000_0000, x});
    @(posedge sys_clk);
  endtask : outs
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    outs(6'b000100);
    rd(8'h08, 32'h0000_0008);
    rd(8'h40, 32'h0000_0000);
    wr(8'h08, 32'h0000_00E8);
    rd(8'h08, 32'h0000_00C8);
    wr(8'h00, 32'h0000_0001);
    wr(8'h08, 32'h0000_0000);
    rd(8'h08, 32'h0000_00C8);
    wr(8'h00, 32'h0000_0003);
    wr(8'h08, 32'h0000_0040);
    rd(8'h08, 32'h0000_0048);
    wr(8'h00, 32'h0000_0041);
    rd(8'h08, 32'h0000_0008);
    wr(8'h10, 32'h0000_0006);
    wr(8'h00, 32'h0000_0031);
    @(negedge sys_clk);
    chk({31'h0000_0000, start}, 32'h0000_0001);
    outs(6'b100010);
    pulse(6'h01);
    outs(6'b100101);
    rd(8'h0C, 32'h0000_0002);
    wr(8'h0C, 32'h0000_0002);
    wr(8'h00, 32'h0000_0021);
    outs(6'b100010);
    pulse(6'h08);
    pulse(6'h08);
    outs(6'b110010);
    pulse(6'h02);
    outs(6'b100010);
    pulse(6'h04);
    outs(6'b100101);
    wr(8'h10, 32'h0000_0001);
    outs(6'b100100);
    wr(8'h0C, 32'h0000_0004);
    pulse(6'h08);
    wr(8'h00, 32'h0000_000D);
    outs(6'b000100);
    wr(8'h00, 32'h0000_003D);
    outs(6'b000010);
    pulse(6'h01);
    wr(8'h0C, 32'h0000_0002);
    wr(8'h00, 32'h0000_0001);
    pulse(6'h10);
    outs(6'b001001);
    wr(8'h00, 32'h0000_0021);
    @(negedge sys_clk);
    chk({31'h0000_0000, start}, 32'h0000_0000);
    outs(6'b001001);
    rd(8'h08, 32'h0000_0020);
    wr(8'h00, 32'h0000_0041);
    outs(6'b000101);
    wr(8'h0C, 32'h0000_0001);
    pulse(6'h20);
    outs(6'b001001);
    wr(8'h00, 32'h0000_0000);
    outs(6'b000101);
    wr(8'h0C, 32'h0000_0001);
    for (int k = 0; k < 16; k++) begin
      e = (k == 0) ? 32'h0000_0000 : 32'h0000_0001 << (k + 15);
      wr(8'h14, 32'(k));
      rd(8'h14, e | 32'(k));
      chk({17'h0_0000, flags}, e >> 16);
    end
    tally_and_finish;
  end
endmodule : alsc_top_bench
`default_nettype wire
